// file: logic/arc_defines.svh
// Constants of the register map and checksum block: offsets, fields,
// reset values and frame counts.
// Assumes it is included by its bare name from the package and modules.
`ifndef ARC_DEFINES_SVH
`define ARC_DEFINES_SVH

// ----------------------------------------------------------------
// Register select codes
// ----------------------------------------------------------------
`define ARC_ADR_CFG1 3'h1
`define ARC_ADR_CFG2 3'h2
`define ARC_ADR_ALERT 3'h3
`define ARC_ADR_LOW 3'h4
`define ARC_ADR_HIGH 3'h5

// ----------------------------------------------------------------
// Reset values and writable masks of the 12 data bits
// ----------------------------------------------------------------
`define ARC_RST_CFG1 12'h000
`define ARC_RST_CFG2 12'h000
`define ARC_RST_LOW 12'h800
`define ARC_RST_HIGH 12'h7FF
`define ARC_MSK_CFG1 12'h3FF
`define ARC_MSK_CFG2 12'h1FF

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ARC_BIT_WR 15
`define ARC_BIT_CRC_W 5
`define ARC_BIT_CRC_R 4

// ----------------------------------------------------------------
// Checksum and frame sizes
// ----------------------------------------------------------------
`define ARC_POLY 9'h107
`define ARC_CRC_BITS 8
`define ARC_CMD_BITS 16
`define ARC_OUT_BITS 40
`define ARC_CMD_LAST 6'h0F
`define ARC_CHK_LAST 6'h17
`define ARC_CNT_MAX 6'h3F
`define ARC_OUT_LEN 6'h28

`endif

// file: logic/arc_pkg.sv
// Types of the register map and checksum block.
// Assumes arc_defines.svh is on the include path.
`include "arc_defines.svh"

package arc_pkg;

  // ----------------------------------------------------------------
  // Command handling state
  // ----------------------------------------------------------------
  typedef enum logic {ARC_ST_IDLE, ARC_ST_WAIT} arc_state_e;

  // ----------------------------------------------------------------
  // Link side state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0] cnt;
    logic [`ARC_CMD_BITS-1:0] shift;
  } arc_frm_s;

  typedef struct packed {
    logic [`ARC_CMD_BITS-1:0] cmd;
    logic [`ARC_CRC_BITS-1:0] chk;
    logic tgl16;
    logic tgl24;
  } arc_hold_s;

  // ----------------------------------------------------------------
  // Core side state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cs1;
    logic cs2;
    logic cs3;
    logic cs4;
    logic [2:0] t16;
    logic [2:0] t24;
    arc_state_e state;
    logic [11:0] cfg1;
    logic [11:0] cfg2;
    logic [11:0] low;
    logic [11:0] high;
    logic [3:0] alarm;
    logic setup_f;
    logic wfail;
    logic [2:0] rd_sel;
    logic [`ARC_OUT_BITS-1:0] out_word;
  } arc_ctl_s;

endpackage : arc_pkg

// file: logic/arc_crc8.sv
// Eight-bit checksum of a message by long division.
// Assumes a message of at least nine bits; purely combinational.
`timescale 1ns/1ps
`default_nettype none
`include "arc_defines.svh"

module arc_crc8
  import arc_pkg::*;
#(
  parameter int MSG_W = 16
) (
  input wire logic [MSG_W-1:0] msg,
  output logic [`ARC_CRC_BITS-1:0] crc
);

  localparam logic [MSG_W+7:0] POLY_EXT = {{(MSG_W-1){1'b0}}, `ARC_POLY};

  logic [MSG_W+7:0] stage [0:MSG_W];

  // ----------------------------------------------------------------
  // Invert the top byte, append a zero byte, then divide
  // ----------------------------------------------------------------
  assign stage[0] = {~msg[MSG_W-1:MSG_W-8], msg[MSG_W-9:0], 8'h00};

  for (genvar i = 0; i < MSG_W; i++) begin : g_div
    // Each stage clears one leading bit, so the chain ends below the divisor
    assign stage[i+1] = stage[i][MSG_W+7-i] ?
                        (stage[i] ^ (POLY_EXT << (MSG_W-1-i))) : stage[i];
  end

  assign crc = stage[MSG_W][7:0];

endmodule : arc_crc8

`default_nettype wire

// file: logic/arc_regmap.sv
// Register map and checksum logic behind the serial command port.
// Assumes sclk, cs_n and sdi come from the host; conversion results,
// alert events and the setup flag come from logic on clk.
`timescale 1ns/1ps
`default_nettype none
`include "arc_defines.svh"

module arc_regmap
  import arc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic [15:0] conv_a,
  input wire logic [15:0] conv_b,
  input wire logic [3:0] alert_evt,
  input wire logic setup_fail,
  output logic serial_out_a,
  output logic [11:0] device_config_primary,
  output logic [11:0] device_config_secondary,
  output logic [11:0] lower_limit,
  output logic [11:0] upper_limit,
  output logic write_check_fail_flag
);

  localparam arc_ctl_s CTL_RST = '{
    cs1: 1'b1, cs2: 1'b1, cs3: 1'b1, cs4: 1'b1,
    t16: 3'h0, t24: 3'h0, state: ARC_ST_IDLE,
    cfg1: `ARC_RST_CFG1, cfg2: `ARC_RST_CFG2,
    low: `ARC_RST_LOW, high: `ARC_RST_HIGH,
    alarm: 4'h0, setup_f: 1'b0, wfail: 1'b0,
    rd_sel: 3'h0, out_word: 40'h00_0000_0000
  };

  // ----------------------------------------------------------------
  // Link side: shift in on rising sclk, shift out on falling sclk
  // ----------------------------------------------------------------
  arc_frm_s frm_r;
  arc_frm_s frm_nxt;
  arc_hold_s hold_r;
  arc_hold_s hold_nxt;
  arc_ctl_s st_r;
  arc_ctl_s st_nxt;
  logic sout_r;
  logic frm_rst;
  logic [5:0] out_idx;

  // The frame ends with chip select, since sclk may stop when it rises
  assign frm_rst = rst | cs_n;
  assign out_idx = `ARC_OUT_LEN - frm_r.cnt;

  always_comb begin
    frm_nxt = frm_r;
    hold_nxt = hold_r;
    frm_nxt.cnt = (frm_r.cnt == `ARC_CNT_MAX) ? frm_r.cnt : frm_r.cnt + 6'h01;
    frm_nxt.shift = {frm_r.shift[14:0], sdi};
    if (frm_r.cnt == `ARC_CMD_LAST) begin
      hold_nxt.cmd = {frm_r.shift[14:0], sdi};
      hold_nxt.tgl16 = ~hold_r.tgl16;
    end
    if (frm_r.cnt == `ARC_CHK_LAST) begin
      hold_nxt.chk = {frm_r.shift[6:0], sdi};
      hold_nxt.tgl24 = ~hold_r.tgl24;
    end
  end

  always_ff @(posedge sclk or posedge frm_rst) begin
    if (frm_rst) begin
      frm_r <= '0;
    end else begin
      frm_r <= frm_nxt;
    end
  end

  // Held words only change at frame marks, so the core reads them after the toggle
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      hold_r <= '0;
    end else begin
      hold_r <= hold_nxt;
    end
  end

  // The readback word is loaded while chip select is high and stays still
  // through the frame, so it is safe to read from this domain.
  always_ff @(negedge sclk or posedge frm_rst) begin
    if (frm_rst) begin
      sout_r <= 1'b0;
    end else begin
      sout_r <= (frm_r.cnt != 6'h00 && frm_r.cnt <= `ARC_OUT_LEN) ?
                st_r.out_word[out_idx] : 1'b0;
    end
  end

  assign serial_out_a = sout_r;

  // ----------------------------------------------------------------
  // Core side: command decode and registers
  // ----------------------------------------------------------------
  logic ev16;
  logic ev24;
  logic cs_rise;
  logic cmd_wr;
  logic [2:0] addr;
  logic [11:0] wdat;
  logic need_chk;
  logic chk_ok;
  logic exec_go;
  logic chk_bad;
  logic rd_valid;
  logic rd_alert;
  logic [7:0] crc_cmd;
  logic [7:0] crc_reg;
  logic [7:0] crc_cnv;
  logic [15:0] rd_word;

  function automatic logic [15:0] reg_value(input logic [2:0] sel, input arc_ctl_s s);
    case (sel)
      `ARC_ADR_CFG1: reg_value = {1'b0, sel, s.cfg1};
      `ARC_ADR_CFG2: reg_value = {1'b0, sel, s.cfg2};
      `ARC_ADR_ALERT: reg_value = {1'b0, sel, 2'b00, s.wfail, s.setup_f, 2'b00,
                                   s.alarm[3:2], 2'b00, s.alarm[1:0]};
      `ARC_ADR_LOW: reg_value = {1'b0, sel, s.low};
      `ARC_ADR_HIGH: reg_value = {1'b0, sel, s.high};
      default: reg_value = 16'h0000;
    endcase
  endfunction : reg_value

  assign ev16 = st_r.t16[1] ^ st_r.t16[2];
  assign ev24 = st_r.t24[1] ^ st_r.t24[2];
  // An extra stage on chip select lets a late checksum mark land first
  assign cs_rise = st_r.cs3 & ~st_r.cs4;
  assign cmd_wr = hold_r.cmd[`ARC_BIT_WR];
  assign addr = hold_r.cmd[14:12];
  assign wdat = hold_r.cmd[11:0];
  assign need_chk = st_r.cfg1[`ARC_BIT_CRC_W] |
                    (cmd_wr & (addr == `ARC_ADR_CFG1) & wdat[`ARC_BIT_CRC_W]);
  assign chk_ok = (crc_cmd == hold_r.chk);
  assign exec_go = (ev16 & ~need_chk) | (ev24 & (st_r.state == ARC_ST_WAIT) & chk_ok);
  assign chk_bad = ev24 & (st_r.state == ARC_ST_WAIT) & ~chk_ok;
  assign rd_valid = (addr >= `ARC_ADR_CFG1) && (addr <= `ARC_ADR_HIGH);
  // Flags clear only once the readback word has latched them, else the read shows zeros
  assign rd_alert = cs_rise & (st_r.rd_sel == `ARC_ADR_ALERT);
  assign rd_word = reg_value(st_r.rd_sel, st_r);

  arc_crc8 #(.MSG_W(16)) u_crc_cmd (
    .msg(hold_r.cmd),
    .crc(crc_cmd)
  );

  arc_crc8 #(.MSG_W(16)) u_crc_reg (
    .msg(rd_word),
    .crc(crc_reg)
  );

  arc_crc8 #(.MSG_W(32)) u_crc_cnv (
    .msg({conv_a, conv_b}),
    .crc(crc_cnv)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.cs1 = cs_n;
    st_nxt.cs2 = st_r.cs1;
    st_nxt.cs3 = st_r.cs2;
    st_nxt.cs4 = st_r.cs3;
    st_nxt.t16 = {st_r.t16[1:0], hold_r.tgl16};
    st_nxt.t24 = {st_r.t24[1:0], hold_r.tgl24};
    // Sticky flags: a new event in the clearing cycle survives
    st_nxt.alarm = (rd_alert ? 4'h0 : st_r.alarm) | alert_evt;
    st_nxt.setup_f = (rd_alert ? 1'b0 : st_r.setup_f) | setup_fail;
    st_nxt.wfail = (rd_alert ? 1'b0 : st_r.wfail) | chk_bad;
    if (ev16 && need_chk) begin
      st_nxt.state = ARC_ST_WAIT;
    end else if (ev24 || cs_rise) begin
      st_nxt.state = ARC_ST_IDLE;
    end
    if (exec_go && cmd_wr) begin
      case (addr)
        `ARC_ADR_CFG1: st_nxt.cfg1 = wdat & `ARC_MSK_CFG1;
        `ARC_ADR_CFG2: st_nxt.cfg2 = wdat & `ARC_MSK_CFG2;
        `ARC_ADR_LOW: st_nxt.low = wdat;
        `ARC_ADR_HIGH: st_nxt.high = wdat;
        default: st_nxt.cfg1 = st_r.cfg1;
      endcase
    end
    if (exec_go && !cmd_wr) begin
      st_nxt.rd_sel = rd_valid ? addr : 3'h0;
    end
    if (cs_rise) begin
      if (st_r.rd_sel != 3'h0) begin
        st_nxt.out_word = {rd_word, st_r.cfg1[`ARC_BIT_CRC_R] ? crc_reg : 8'h00,
                           16'h0000};
      end else begin
        st_nxt.out_word = {conv_a, conv_b,
                           st_r.cfg1[`ARC_BIT_CRC_R] ? crc_cnv : 8'h00};
      end
      st_nxt.rd_sel = 3'h0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= CTL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign device_config_primary = st_r.cfg1;
  assign device_config_secondary = st_r.cfg2;
  assign lower_limit = st_r.low;
  assign upper_limit = st_r.high;
  assign write_check_fail_flag = st_r.wfail;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  wr_cfg1_a: assert property (exec_go && cmd_wr && addr == `ARC_ADR_CFG1 |=>
    st_r.cfg1 == ($past(wdat) & `ARC_MSK_CFG1))
    else $error("config write not stored");

  ro_keep_a: assert property (exec_go && cmd_wr && addr == `ARC_ADR_ALERT |=>
    $stable(st_r.cfg1) && $stable(st_r.cfg2) && $stable(st_r.low) && $stable(st_r.high))
    else $error("write to read-only register changed state");

  bad_addr_wr_a: assert property (exec_go && cmd_wr && (addr == 3'h0 || addr > `ARC_ADR_HIGH)
    |=> $stable(st_r.cfg1) && $stable(st_r.low) && $stable(st_r.high))
    else $error("write to undefined address changed state");

  rd_sel_set_a: assert property (exec_go && !cmd_wr && rd_valid && !cs_rise |=>
    st_r.rd_sel == $past(addr))
    else $error("valid read did not select readback");

  bad_addr_rd_a: assert property (exec_go && !cmd_wr && !rd_valid |=>
    st_r.rd_sel == 3'h0)
    else $error("undefined read selected readback");

  conv_word_a: assert property (cs_rise && st_r.rd_sel == 3'h0 |=>
    st_r.out_word[39:8] == $past({conv_a, conv_b}))
    else $error("conversion word not loaded");

  crc_read_a: assert property (cs_rise && st_r.rd_sel == 3'h0 |=>
    st_r.out_word[7:0] == ($past(st_r.cfg1[`ARC_BIT_CRC_R]) ? $past(crc_cnv) : 8'h00))
    else $error("read checksum wrong");

  defer_chk_a: assert property (ev16 && need_chk |=>
    st_r.state == ARC_ST_WAIT && $stable(st_r.cfg1))
    else $error("checked frame applied early");

  bad_chk_drop_a: assert property (chk_bad |=>
    $stable(st_r.cfg1) && st_r.wfail && st_r.state == ARC_ST_IDLE)
    else $error("bad checksum frame not dropped");

  cmd_capture_a: assert property (@(posedge sclk) disable iff (frm_rst)
    frm_r.cnt == `ARC_CMD_LAST |=> hold_r.tgl16 != $past(hold_r.tgl16))
    else $error("command not captured at last bit");

  reg_word_a: assert property (cs_rise && st_r.rd_sel != 3'h0 |=>
    st_r.out_word[39:24] == $past(rd_word) && st_r.out_word[15:0] == 16'h0000)
    else $error("register readback word not loaded");

  reg_crc_a: assert property (cs_rise && st_r.rd_sel != 3'h0 |=>
    st_r.out_word[23:16] == ($past(st_r.cfg1[`ARC_BIT_CRC_R]) ? $past(crc_reg) : 8'h00))
    else $error("readback checksum wrong");

  alert_clear_a: assert property (rd_alert && alert_evt == 4'h0 && !setup_fail &&
    !chk_bad |=> st_r.alarm == 4'h0 && !st_r.setup_f && !st_r.wfail)
    else $error("alert flags not cleared after readback");

  out_idle_a: assert property (cs_n |-> !serial_out_a)
    else $error("serial output active outside a frame");

  alert_read_c: cover property (rd_alert);
  wchk_on_c: cover property (exec_go && cmd_wr && addr == `ARC_ADR_CFG1 &&
    wdat[`ARC_BIT_CRC_W]);
  reg_read_c: cover property (cs_rise && st_r.rd_sel != 3'h0);
  conv_read_c: cover property (cs_rise && st_r.rd_sel == 3'h0 && st_r.cfg1[`ARC_BIT_CRC_R]);
  bad_chk_c: cover property (chk_bad);

endmodule : arc_regmap

`default_nettype wire

// file: test/arc_host_model.sv
// Host model for the serial command port: frames commands on sdi and
// collects serial_out_a. Assumes the bench runs one xfer at a time.
`timescale 1ns/1ps
`default_nettype none

module arc_host_model (
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic serial_out_a
);
  // ----------------------------------------------------------------
  // Frame task
  // ----------------------------------------------------------------
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end

  // The serial clock stands still between frames; a released sdi toggles
  // so that stale data cannot pass for a command bit
  task automatic xfer(input logic [23:0] tx, input int nbits, output logic [39:0] rx);
    rx = '0;
    cs_n = 1'b0;
    sdi = tx[23];
    #24;
    for (int i = 1; i <= 41; i++) begin
      sclk = 1'b1;
      if (i >= 2) rx[41-i] = serial_out_a;
      #24;
      sclk = 1'b0;
      sdi = (i < nbits) ? tx[23-i] : ~sdi;
      #24;
    end
    cs_n = 1'b1;
    #100;
  endtask : xfer
endmodule : arc_host_model
`default_nettype wire

// file: test/tb_adc_register_map_crc.sv
// Self-checking bench of the register map and checksum block.
// Assumes arc_pkg and the host model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "arc_defines.svh"

module tb_adc_register_map_crc
  import arc_pkg::*;
;
  logic clk, rst, sclk, cs_n, sdi, setup_fail, serial_out_a, write_check_fail_flag;
  logic [15:0] conv_a, conv_b;
  logic [3:0] alert_evt;
  logic [11:0] device_config_primary, device_config_secondary, lower_limit, upper_limit;
  logic [11:0] d;
  logic [39:0] next_word;
  int num_errors = 0;
  int cmp_count = 0;
  int regs[8];
  int msk[8] = '{0, 12'h3FF, 12'h1FF, 0, 12'hFFF, 12'hFFF, 0, 0};
  int alarm = 0;
  bit primed = 0;

  arc_regmap arc_regmap_inst (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .conv_a(conv_a), .conv_b(conv_b), .alert_evt(alert_evt), .setup_fail(setup_fail),
    .serial_out_a(serial_out_a), .device_config_primary(device_config_primary),
    .device_config_secondary(device_config_secondary), .lower_limit(lower_limit),
    .upper_limit(upper_limit), .write_check_fail_flag(write_check_fail_flag));
  arc_host_model arc_host_model_inst (.sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .serial_out_a(serial_out_a));

  // ----------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------
  function automatic logic [7:0] crc8(input logic [31:0] m, input int w);
    logic [39:0] v;
    v = {m, 8'h00};
    v[w+7 -: 8] = ~v[w+7 -: 8];
    for (int i = w + 7; i >= 8; i--) begin
      if (v[i]) v[i -: 9] = v[i -: 9] ^ 9'h107;
    end
    return v[7:0];
  endfunction : crc8

  task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic check_regs;
    check("cfg1", device_config_primary, regs[1][11:0]);
    check("cfg2", device_config_secondary, regs[2][11:0]);
    check("low", lower_limit, regs[4][11:0]);
    check("high", upper_limit, regs[5][11:0]);
    check("wfail", write_check_fail_flag, alarm[9]);
  endtask : check_regs

  task automatic set_conv(input logic [15:0] ca, input logic [15:0] cb);
    @(posedge clk);
    #1 conv_a = ca;
    conv_b = cb;
  endtask : set_conv

  // One frame; the readout of each frame after the first was predicted by the one before
  task automatic frame(input logic [15:0] cmd, input bit bad);
    logic [39:0] rx;
    logic [15:0] w;
    int a;
    bit chkd;
    a = cmd[14:12];
    chkd = regs[1][5] || (cmd[15] && a == 1 && cmd[5]);
    arc_host_model_inst.xfer({cmd, crc8({16'h0000, cmd}, 16) ^ (bad ? 8'h01 : 8'h00)},
      chkd ? 24 : 16, rx);
    if (primed) check("readout", rx, next_word);
    primed = 1;
    w = 16'h0000;
    if (chkd && bad) alarm[9] = 1'b1;
    else if (cmd[15] && msk[a] != 0) regs[a] = cmd[11:0] & msk[a];
    else if (!cmd[15] && a >= 1 && a <= 5) w = {1'b0, cmd[14:12], a == 3 ? alarm[11:0] : regs[a][11:0]};
    if (w != 16'h0000) next_word = {w, regs[1][4] ? crc8({16'h0000, w}, 16) : 8'h00, 16'h0000};
    else next_word = {conv_a, conv_b, regs[1][4] ? crc8({conv_a, conv_b}, 32) : 8'h00};
    if (w[14:12] == 3'h3) alarm = 0;
    check_regs();
  endtask : frame

  task automatic report_and_stop;
    $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------------------------------
  initial clk = 1'b0;
  always #2 clk = ~clk;

  // Roughly 32 frames of 2.1 us each are expected
  initial begin
    #300000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    conv_a = 16'h0000;
    conv_b = 16'h0000;
    alert_evt = 4'h0;
    setup_fail = 1'b0;
    regs = '{default: 0};
    regs[4] = 12'h800;
    regs[5] = 12'h7FF;
    void'($urandom(32'hEFD68768));
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    repeat (2) @(posedge clk);
    check_regs();
    $display("test reset values done");
    for (int a = 0; a < 8; a++) begin
      d = 12'($urandom) & 12'hFDF;
      set_conv(16'($urandom), 16'($urandom));
      frame({1'b1, a[2:0], d}, 1'b0);
      set_conv(16'($urandom), 16'($urandom));
      frame({1'b0, a[2:0], 12'hABC}, 1'b0);
    end
    frame(16'h0000, 1'b0);
    $display("test register access done");
    @(posedge clk);
    #1 alert_evt = 4'hF;
    setup_fail = 1'b1;
    @(posedge clk);
    #1 alert_evt = 4'h0;
    setup_fail = 1'b0;
    alarm = alarm | 12'h133;
    frame(16'h3000, 1'b0);
    frame(16'h3000, 1'b0);
    frame(16'h0000, 1'b0);
    $display("test alert flags done");
    frame(16'h9010, 1'b0);
    set_conv(16'hAAAA, 16'h5555);
    frame(16'h0000, 1'b0);
    frame(16'h4000, 1'b0);
    frame(16'h0000, 1'b0);
    $display("test read checksum done");
    frame(16'h9030, 1'b1);
    frame(16'h9030, 1'b0);
    frame(16'hC123, 1'b1);
    frame(16'hC456, 1'b0);
    frame(16'h3000, 1'b0);
    frame(16'h9010, 1'b0);
    frame(16'hC789, 1'b0);
    frame(16'h0000, 1'b0);
    $display("test write checksum done");
    report_and_stop();
  end
endmodule : tb_adc_register_map_crc
`default_nettype wire
